// ### design/tdpp_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the playback block.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef TDPP_DEFINES_SVH
`define TDPP_DEFINES_SVH

// Bit positions inside one 32-bit pattern word.
`define TDPP_BIT_PAYLOAD     0
`define TDPP_BIT_BURST       2
`define TDPP_BIT_EVENT       6
`define TDPP_BIT_RESTART     7

// Fixed value of all bits that never change (bit 4 reads one, the rest zero).
`define TDPP_WORD_FIXED      32'h0000_0010

// Timeslot geometry in bit periods.
`define TDPP_SLOT_LAST       8'd155
`define TDPP_SLOT_LAST_GUARD 8'd156
`define TDPP_SLOTS_LAST      3'h7
`define TDPP_FIELD_LEN       16'd57
`define TDPP_FIELD1_START    8'd3
`define TDPP_FIELD2_START    8'd88

// Memory allocation: bytes per block and bytes per word.
`define TDPP_BLOCK_BYTES     1024
`define TDPP_WORD_BYTES      4

// Rate limits in kbit/s (symbol ceiling for each filter width).
`define TDPP_SERIAL_MAX_KBPS 20'd50000
`define TDPP_CEIL_F16_KBPS   20'd50000
`define TDPP_CEIL_F32_KBPS   20'd25000
`define TDPP_CEIL_F64_KBPS   20'd12500

// Clock rate and default bit period.
`define TDPP_CLK_HZ          40000000
`define TDPP_BIT_RATE_HZ     1000000
`define TDPP_BIT_DIV         (`TDPP_CLK_HZ / `TDPP_BIT_RATE_HZ)

// Pseudo-random generator seed.
`define TDPP_PN_SEED         9'h1ff

`endif

// ### design/tdpp_fifo.sv
// Purpose: Small synchronous FIFO that buffers incoming user data bits.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Depth must be a power of two; read data shows ahead.
`timescale 1ns/10ps
module tdpp_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Fill side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];   // Storage words.
  logic [AW-1:0] wr_ptr;       // Next slot to write.
  logic [AW-1:0] rd_ptr;       // Next slot to read.
  logic [AW:0]   count;        // Words held, one bit wider to tell full from empty.
  logic          push;         // Word accepted this cycle.
  logic          pop;          // Word removed this cycle.

  // Empty comes from the count; ready is a flop fed by the count after the edge.
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      in_ready <= (push == pop) ? in_ready : (pop || count != DEPTH[AW:0] - 1'b1);
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ### design/tdpp_pkg.sv
// Purpose: Types shared by the playback block.
// Assumes: Nothing beyond the language.
// Notes:   Numbers live in the defines header; only types are here.
package tdpp_pkg;

  // Where the event pulse is placed.
  typedef enum logic [1:0] {
    SYNC_FRAME,
    SYNC_SLOT,
    SYNC_ALL,
    SYNC_NONE
  } tdpp_sync_t;

  // FIR filter width selection.
  typedef enum logic [1:0] {
    FILT_16,
    FILT_32,
    FILT_64,
    FILT_RSVD
  } tdpp_filter_t;

  // Playback sequencer states.
  typedef enum logic {
    ST_IDLE,
    ST_PLAY
  } tdpp_state_t;

endpackage

// ### design/tdpp_playback.sv
// Purpose: Builds and plays back framed TDMA pattern words, one word per bit period.
// Assumes: All inputs synchronous to CLK; configuration held while ENABLE is high.
// Notes:   Words are produced on the fly in address order, so no full image is stored.
`timescale 1ns/10ps
`include "tdpp_defines.svh"

// Behaviour
// - User bits fill active slot, frame after frame
// - Active slot word: burst one, user payload
// - Inactive slot word: burst zero, payload free
// - Restart flag ends pattern after last bit
// - Restart at bit seven, final word only
// - Pattern static during playback, reloaded on change (code reloads only after ENABLE drops and rises)
// - 156-bit slots, guard bit every fourth
// - Two 57-bit data fields per slot
// - One 32-bit word per bit period
// - Event at frame, chosen slot or all
// - Each slot has exactly one data source
// - Above 50 Mbps use parallel mode
// - Parallel only for continuous custom stream
// - One bit per symbol always serial
// - Max rate is bits times filter ceiling
// - Eight bits narrow filter reaches 400 Mbps
// - Event widened by bits per symbol in parallel
// - Framed image built, original data kept
// - Memory counted in rounded-up 1024-byte blocks
// - Restart zero advances, one returns to start
// - Only bits 0, 2, 6, 7 vary
module tdpp_playback #(
  parameter int BIT_DIV    = `TDPP_BIT_DIV,
  parameter int ADDR_W     = 21,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // Configuration, sampled when ENABLE rises.
  input  wire logic              ENABLE,
  input  wire logic [7:0]        SLOT_ON,
  input  wire logic [7:0]        SLOT_USER,
  input  wire logic [1:0]        SYNC_OUT_SELECT,
  input  wire logic [2:0]        SYNC_SLOT,
  input  wire logic [15:0]       FILE_BITS,
  input  wire logic [19:0]       BIT_RATE_KBPS,
  input  wire logic [3:0]        BITS_PER_SYMBOL,
  input  wire logic [1:0]        FILTER_SELECT,
  input  wire logic              CONTINUOUS_STREAM,
  input  wire logic              DIRECT_PATTERN,
  // User data bits.
  input  wire logic              USER_VALID,
  input  wire logic              USER_BIT,
  output logic                   USER_READY,
  // Pattern word stream.
  output logic                   WORD_VALID,
  output logic [31:0]            WORD,
  output logic [ADDR_W-1:0]      ADDR,
  // Pins toward modulator and trigger hardware.
  output logic                   BURST_GATE,
  output logic                   EVENT_OUT,
  // Status.
  output logic                   PLAYING,
  output logic                   PARALLEL_MODE,
  output logic                   RATE_ERROR,
  output logic [15:0]            BLOCKS_NEEDED
);

  localparam int DIV_W = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  // Ceiling rate of one filter width, in kbit/s per bit of symbol.
  function automatic logic [19:0] ceil_kbps(input logic [1:0] f);
    unique case (f)
      tdpp_pkg::FILT_16: ceil_kbps = `TDPP_CEIL_F16_KBPS;
      tdpp_pkg::FILT_32: ceil_kbps = `TDPP_CEIL_F32_KBPS;
      default:           ceil_kbps = `TDPP_CEIL_F64_KBPS;
    endcase
  endfunction

  // Last bit index of a slot; slots 3 and 7 carry the extra guard bit.
  function automatic logic [7:0] slot_last(input logic [2:0] s);
    slot_last = (s[1:0] == 2'b11) ? `TDPP_SLOT_LAST_GUARD : `TDPP_SLOT_LAST;
  endfunction

  // True when the bit position lies in either data field.
  function automatic logic in_field(input logic [7:0] b);
    in_field = ((b >= `TDPP_FIELD1_START) && (b < (`TDPP_FIELD1_START + 8'd57))) ||
               ((b >= `TDPP_FIELD2_START) && (b < (`TDPP_FIELD2_START + 8'd57)));
  endfunction

  tdpp_pkg::tdpp_state_t state;       // Sequencer state.
  logic [7:0]        cfg_on;          // Latched slot-on mask.
  logic [7:0]        cfg_user;        // Latched user-source mask.
  logic [1:0]        cfg_sync;        // Latched event placement.
  logic [2:0]        cfg_sync_slot;   // Latched slot for slot-sync.
  logic [15:0]       cfg_bits;        // Latched file length in bits.
  logic [3:0]        cfg_width;       // Event width in bit periods.
  logic [DIV_W-1:0]  div_cnt;         // Bit-period divider.
  logic              bit_tick;        // Bit-period enable, held until the word is emitted.
  logic [7:0]        bit_idx;         // Bit position in the slot.
  logic [2:0]        slot_idx;        // Slot in the frame.
  logic [ADDR_W-1:0] addr;            // Word address being built.
  logic [15:0]       bits_left;       // User bits still to place this pass.
  logic              field_ok;        // Current field has enough bits.
  logic              done;            // Last user bit already placed.
  logic [8:0]        pn;              // Pseudo-random register.
  logic [3:0]        ev_cnt;          // Remaining stretched event periods.
  logic              fifo_valid;      // A user bit is waiting.
  logic              fifo_bit;        // That bit.
  logic              fifo_pop;        // Take the bit this period.
  logic              user_slot;       // Current slot is on and fed from the file.
  logic              field_start;     // First bit of a data field.
  logic              take;            // This word carries a user bit.
  logic              frame_end;       // Last word of the frame.
  logic              done_now;        // Pattern end is reached in this frame.
  logic              restart;         // This word carries the restart flag.
  logic              advance;         // Emit one word now.
  logic              ev_start;        // Event begins on this word.
  logic              ev_bit;          // Event bit of this word.
  logic              payload;         // Payload bit of this word.
  logic [31:0]       next_word;       // Word being emitted.
  logic              rate_ok;         // Requested rate is reachable.
  logic              par_req;         // Rate asks for parallel mode.
  logic [19:0]       max_kbps;        // Reachable rate limit.

  // Input bits pass through the FIFO so a slow source is absorbed; when it runs
  // dry the bit clock stalls rather than sending a wrong payload.
  tdpp_fifo #(
    .W     (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .in_valid  (USER_VALID),
    .in_data   (USER_BIT),
    .in_ready  (USER_READY),
    .out_valid (fifo_valid),
    .out_data  (fifo_bit),
    .out_ready (fifo_pop)
  );

  // Rate limit and mode choice.
  assign max_kbps = 20'(BITS_PER_SYMBOL * ceil_kbps(FILTER_SELECT));
  assign rate_ok  = (BIT_RATE_KBPS <= max_kbps);
  assign par_req  = (BIT_RATE_KBPS > `TDPP_SERIAL_MAX_KBPS)
                    && (BITS_PER_SYMBOL > 4'd1)
                    && CONTINUOUS_STREAM && !DIRECT_PATTERN;

  // Decode of the word at the current address.
  always_comb
  begin
    user_slot   = cfg_on[slot_idx] && cfg_user[slot_idx];
    field_start = (bit_idx == `TDPP_FIELD1_START) || (bit_idx == `TDPP_FIELD2_START);
    // A field is filled only if the whole field can be filled.
    if (field_start)
    begin
      take = user_slot && !done && (bits_left >= `TDPP_FIELD_LEN);
    end
    else
    begin
      take = user_slot && in_field(bit_idx) && field_ok && !done;
    end
    frame_end = (slot_idx == `TDPP_SLOTS_LAST) && (bit_idx == slot_last(slot_idx));
    // Without any user slot the pattern is a single frame.
    done_now = done || (cfg_user & cfg_on) == 8'h00
               || (take && (bits_left == 16'd1))
               || (field_start && user_slot && (bits_left < `TDPP_FIELD_LEN));
    restart  = frame_end && done_now;
    advance  = (state == tdpp_pkg::ST_PLAY) && bit_tick && !(take && !fifo_valid);
    fifo_pop = advance && take;
    // Event placement follows the sync selection.
    unique case (cfg_sync)
      tdpp_pkg::SYNC_FRAME: ev_start = (bit_idx == 8'd0) && (slot_idx == 3'd0);
      tdpp_pkg::SYNC_SLOT:  ev_start = (bit_idx == 8'd0) && (slot_idx == cfg_sync_slot);
      tdpp_pkg::SYNC_ALL:   ev_start = (bit_idx == 8'd0);
      default:              ev_start = 1'b0;
    endcase
    ev_bit = ev_start || (ev_cnt != 4'd0);
    // Inactive slots and control positions of user slots send zero payload.
    if (take)
    begin
      payload = fifo_bit;
    end
    else if (cfg_on[slot_idx] && !cfg_user[slot_idx])
    begin
      payload = pn[0];
    end
    else
    begin
      payload = 1'b0;
    end
    next_word = `TDPP_WORD_FIXED;
    next_word[`TDPP_BIT_PAYLOAD] = payload;
    next_word[`TDPP_BIT_BURST]   = cfg_on[slot_idx];
    next_word[`TDPP_BIT_EVENT]   = ev_bit;
    next_word[`TDPP_BIT_RESTART] = restart;
  end

  // Bit-period divider; it idles while stopped so the first word is a full period late.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      div_cnt  <= '0;
      bit_tick <= 1'b0;
    end
    else if (state != tdpp_pkg::ST_PLAY)
    begin
      div_cnt  <= '0;
      bit_tick <= 1'b0;
    end
    else if (bit_tick && !advance)
    begin
      // Hold the enable while the FIFO is empty so no period is lost.
      bit_tick <= 1'b1;
    end
    else if (div_cnt == DIV_W'(BIT_DIV - 1))
    begin
      div_cnt  <= '0;
      bit_tick <= 1'b1;
    end
    else
    begin
      div_cnt  <= div_cnt + 1'b1;
      bit_tick <= 1'b0;
    end
  end

  // Sequencer and configuration capture; a change of format needs ENABLE to drop.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state         <= tdpp_pkg::ST_IDLE;
      cfg_on        <= 8'h00;
      cfg_user      <= 8'h00;
      cfg_sync      <= 2'h0;
      cfg_sync_slot <= 3'h0;
      cfg_bits      <= 16'h0000;
      cfg_width     <= 4'h1;
      PARALLEL_MODE <= 1'b0;
      RATE_ERROR    <= 1'b0;
    end
    else
    begin
      unique case (state)
        tdpp_pkg::ST_IDLE:
        begin
          RATE_ERROR <= ENABLE && !rate_ok;
          // Refuse to start on an unreachable rate.
          if (ENABLE && rate_ok)
          begin
            state         <= tdpp_pkg::ST_PLAY;
            cfg_on        <= SLOT_ON;
            cfg_user      <= SLOT_USER;
            cfg_sync      <= SYNC_OUT_SELECT;
            cfg_sync_slot <= SYNC_SLOT;
            cfg_bits      <= FILE_BITS;
            PARALLEL_MODE <= par_req;
            cfg_width     <= par_req ? BITS_PER_SYMBOL : 4'h1;
          end
        end
        tdpp_pkg::ST_PLAY:
        begin
          // Inputs are ignored until playback stops.
          if (!ENABLE)
          begin
            state <= tdpp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Slot, bit and address counters.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bit_idx  <= 8'h00;
      slot_idx <= 3'h0;
      addr     <= '0;
    end
    else if (state != tdpp_pkg::ST_PLAY)
    begin
      bit_idx  <= 8'h00;
      slot_idx <= 3'h0;
      addr     <= '0;
    end
    else if (advance)
    begin
      if (restart)
      begin
        addr <= '0;
      end
      else
      begin
        addr <= addr + 1'b1;
      end
      if (bit_idx == slot_last(slot_idx))
      begin
        bit_idx  <= 8'h00;
        slot_idx <= slot_idx + 1'b1;
      end
      else
      begin
        bit_idx <= bit_idx + 1'b1;
      end
    end
  end

  // User-bit bookkeeping for one pass through the file.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bits_left <= 16'h0000;
      field_ok  <= 1'b0;
      done      <= 1'b0;
    end
    else if (state != tdpp_pkg::ST_PLAY)
    begin
      bits_left <= FILE_BITS;
      field_ok  <= 1'b0;
      done      <= 1'b0;
    end
    else if (advance)
    begin
      if (restart)
      begin
        // The source replays its retained copy from the first bit.
        bits_left <= cfg_bits;
        field_ok  <= 1'b0;
        done      <= 1'b0;
      end
      else
      begin
        if (field_start)
        begin
          field_ok <= take;
        end
        if (take)
        begin
          bits_left <= bits_left - 16'd1;
        end
        done <= done_now;
      end
    end
  end

  // Pseudo-random source for slots without a user file, and event stretch count.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pn     <= `TDPP_PN_SEED;
      ev_cnt <= 4'h0;
    end
    else if (advance)
    begin
      if (cfg_on[slot_idx] && !cfg_user[slot_idx])
      begin
        pn <= {pn[4] ^ pn[0], pn[8:1]};
      end
      if (ev_start)
      begin
        ev_cnt <= cfg_width - 4'd1;
      end
      else if (ev_cnt != 4'd0)
      begin
        ev_cnt <= ev_cnt - 4'd1;
      end
    end
  end

  // Registered outputs; BURST_GATE and EVENT_OUT hold for the whole bit period.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      WORD_VALID    <= 1'b0;
      WORD          <= `TDPP_WORD_FIXED;
      ADDR          <= '0;
      BURST_GATE    <= 1'b0;
      EVENT_OUT     <= 1'b0;
      PLAYING       <= 1'b0;
      BLOCKS_NEEDED <= 16'h0000;
    end
    else
    begin
      WORD_VALID <= advance;
      PLAYING    <= (state == tdpp_pkg::ST_PLAY);
      if (state != tdpp_pkg::ST_PLAY)
      begin
        BURST_GATE <= 1'b0;
        EVENT_OUT  <= 1'b0;
      end
      else if (advance)
      begin
        WORD       <= next_word;
        ADDR       <= addr;
        BURST_GATE <= next_word[`TDPP_BIT_BURST];
        EVENT_OUT  <= next_word[`TDPP_BIT_EVENT];
        // Blocks = ceil(words * 4 / 1024), taken from the length of the last pass.
        if (restart)
        begin
          BLOCKS_NEEDED <= 16'(((32'(addr) + 32'd1) * `TDPP_WORD_BYTES
                                + `TDPP_BLOCK_BYTES - 1) / `TDPP_BLOCK_BYTES);
        end
      end
    end
  end

endmodule

// ### testbench/tdpp_playback_monitor.sv
// Purpose: Port-level checks on the playback block.
// Assumes: Bound to every tdpp_playback instance; BIT_DIV is at least 2.
// Notes:   Watches only the ports that the checks need.
`timescale 1ns/10ps
`include "tdpp_defines.svh"
module tdpp_playback_monitor #(
  parameter int BIT_DIV = 2,
  parameter int ADDR_W  = 21
) (
  // Clock, reset and configuration.
  input wire logic              CLK,
  input wire logic              ARST_N,
  input wire logic [3:0]        BITS_PER_SYMBOL,
  input wire logic              DIRECT_PATTERN,
  // Outputs under watch.
  input wire logic              WORD_VALID,
  input wire logic [31:0]       WORD,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic              BURST_GATE,
  input wire logic              EVENT_OUT,
  input wire logic              PLAYING,
  input wire logic              PARALLEL_MODE,
  input wire logic              RATE_ERROR
);
  localparam int START_MAX = BIT_DIV + 1; // Start to first word, with slack.
  logic              seen;      // A word has been seen since playback began.
  logic              rst_prev;  // Restart flag of the previous word.
  logic [ADDR_W-1:0] addr_prev; // Address of the previous word.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Remember the last word to predict the next address across the wrap.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      seen      <= 1'b0;
      rst_prev  <= 1'b0;
      addr_prev <= '0;
    end
    else if (!PLAYING)
      seen <= 1'b0;
    else if (WORD_VALID)
    begin
      seen      <= 1'b1;
      rst_prev  <= WORD[`TDPP_BIT_RESTART];
      addr_prev <= ADDR;
    end
  end
  sequence s_start; $rose(PLAYING); endsequence
  sequence s_word; WORD_VALID; endsequence
  property p_pins; s_word |-> BURST_GATE == WORD[2] && EVENT_OUT == WORD[6]; endproperty
  property p_fixed; s_word |-> (WORD & ~32'h0000_00c5) == `TDPP_WORD_FIXED; endproperty
  property p_addr; s_word and seen |-> ADDR == (rst_prev ? '0 : addr_prev + 1'b1); endproperty
  property p_gap; s_word |=> !WORD_VALID; endproperty
  property p_start; s_start |-> ##[1:START_MAX] s_word; endproperty
  property p_idle; !PLAYING |-> !BURST_GATE && !EVENT_OUT && !WORD_VALID; endproperty
  property p_rate; RATE_ERROR |=> !PLAYING; endproperty
  property p_serial; PLAYING && BITS_PER_SYMBOL == 4'h1 |-> !PARALLEL_MODE; endproperty
  property p_direct; PLAYING && DIRECT_PATTERN |-> !PARALLEL_MODE; endproperty
  a_pins: assert property (p_pins) else $error("pins differ from word");
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  a_addr: assert property (p_addr) else $error("address order wrong");
  a_gap: assert property (p_gap) else $error("words too close");
  a_start: assert property (p_start) else $error("first word late");
  a_idle: assert property (p_idle) else $error("output while stopped");
  a_rate: assert property (p_rate) else $error("started at bad rate");
  a_serial: assert property (p_serial) else $error("one bit went parallel");
  a_direct: assert property (p_direct) else $error("direct went parallel");
endmodule
bind tdpp_playback tdpp_playback_monitor #(.BIT_DIV(BIT_DIV), .ADDR_W(ADDR_W)) u_mon (
  .CLK(CLK), .ARST_N(ARST_N), .BITS_PER_SYMBOL(BITS_PER_SYMBOL),
  .DIRECT_PATTERN(DIRECT_PATTERN), .WORD_VALID(WORD_VALID), .WORD(WORD), .ADDR(ADDR),
  .BURST_GATE(BURST_GATE), .EVENT_OUT(EVENT_OUT), .PLAYING(PLAYING),
  .PARALLEL_MODE(PARALLEL_MODE), .RATE_ERROR(RATE_ERROR));

// ### testbench/tdpp_playback_tb.sv
// Purpose: Self-checking bench for the playback block.
// Assumes: Short bit period BD; one word per bit period.
// Notes:   Each played word is predicted from slot map and setup.
`timescale 1ns/10ps
`include "tdpp_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tdpp_playback_tb;
  localparam int BD = 2; // Short bit period.
  logic        CLK = 1'b0, ARST_N = 1'b0, ENABLE = 1'b0, CONTINUOUS_STREAM = 1'b1;
  logic [7:0]  SLOT_ON = 8'h00, SLOT_USER = 8'h00;
  logic [1:0]  SYNC_OUT_SELECT = 2'h0, FILTER_SELECT = 2'h0;
  logic [2:0]  SYNC_SLOT = 3'h0;
  logic [15:0] FILE_BITS = 16'h00e4;
  logic [19:0] BIT_RATE_KBPS = 20'h003e8;
  logic [3:0]  BITS_PER_SYMBOL = 4'h1;
  logic        USER_VALID, USER_BIT, USER_READY, WORD_VALID, BURST_GATE, EVENT_OUT;
  logic        PLAYING, PARALLEL_MODE, RATE_ERROR, chk = 1'b0, DIRECT_PATTERN = 1'b0;
  logic [31:0] WORD;
  logic [20:0] ADDR;
  logic [15:0] BLOCKS_NEEDED;
  int          n_errors = 0, compares = 0, n_taken = 0, exp_addr, n_words, last_a, ew;
  int          starts [8] = '{0, 156, 312, 468, 625, 781, 937, 1093}; // Slots 3, 7 carry guard.
  always #12.5 CLK = ~CLK;
  tdpp_playback #(.BIT_DIV(BD)) u_tdpp_playback (
    .CLK(CLK), .ARST_N(ARST_N), .ENABLE(ENABLE), .SLOT_ON(SLOT_ON), .SLOT_USER(SLOT_USER),
    .SYNC_OUT_SELECT(SYNC_OUT_SELECT), .SYNC_SLOT(SYNC_SLOT), .FILE_BITS(FILE_BITS),
    .BIT_RATE_KBPS(BIT_RATE_KBPS), .BITS_PER_SYMBOL(BITS_PER_SYMBOL),
    .FILTER_SELECT(FILTER_SELECT), .CONTINUOUS_STREAM(CONTINUOUS_STREAM),
    .DIRECT_PATTERN(DIRECT_PATTERN), .USER_VALID(USER_VALID), .USER_BIT(USER_BIT),
    .USER_READY(USER_READY), .WORD_VALID(WORD_VALID), .WORD(WORD), .ADDR(ADDR),
    .BURST_GATE(BURST_GATE), .EVENT_OUT(EVENT_OUT), .PLAYING(PLAYING),
    .PARALLEL_MODE(PARALLEL_MODE), .RATE_ERROR(RATE_ERROR), .BLOCKS_NEEDED(BLOCKS_NEEDED));
  tdpp_user_source u_tdpp_user_source (
    .clk(CLK), .arst_n(ARST_N), .file_bits(FILE_BITS), .ready(USER_READY),
    .restart(WORD_VALID && WORD[7]), .valid(USER_VALID), .bit_out(USER_BIT));
  // The file pattern the source sends, bit by bit.
  function automatic logic pat(input int i);
    return i[0] ^ i[2] ^ i[5];
  endfunction
  // Print the verdict and end the run.
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Predict one word from its place in the frame.
  task automatic check_word();
    int p, f, s, o, k;
    p = exp_addr % 1250;
    f = exp_addr / 1250;
    s = 0;
    for (int i = 1; i < 8; i++)
      if (p >= starts[i]) s = i;
    o = p - starts[s];
    k = (o >= 3 && o < 60) ? o - 3 : (o >= 88 && o < 145) ? o - 31 : -1;
    `CHK(ADDR, 21'(exp_addr))
    `CHK(WORD[2], SLOT_ON[s])
    if (!SLOT_ON[s]) `CHK(WORD[0], 1'b0)
    else if (SLOT_USER[s] && k >= 0) `CHK(WORD[0], pat(f * 114 + k))
    `CHK(WORD[7], exp_addr == last_a)
    `CHK(WORD[6], o < ew && (SYNC_OUT_SELECT == 2 || (SYNC_OUT_SELECT == 1 && s == SYNC_SLOT)
      || (SYNC_OUT_SELECT == 0 && s == 0)))
    if (WORD[7] === 1'b1 && SLOT_USER != 0) `CHK(n_taken, 228)
    exp_addr = WORD[7] ? 0 : exp_addr + 1;
    n_words++;
  endtask
  // Count bits handed over and check every played word.
  always @(posedge CLK)
  begin
    if (ARST_N === 1'b1 && USER_VALID === 1'b1 && USER_READY === 1'b1) n_taken++;
    if (chk && WORD_VALID === 1'b1) check_word();
  end
  // Play one setup for a number of words, then stop.
  task automatic run(input logic [7:0] on, user, input logic [1:0] sel, input logic [2:0] ss,
                     input logic [19:0] rate, input logic [3:0] bps, input int w, last, words);
    @(posedge CLK);
    SLOT_ON <= on;
    SLOT_USER <= user;
    SYNC_OUT_SELECT <= sel;
    SYNC_SLOT <= ss;
    BIT_RATE_KBPS <= rate;
    BITS_PER_SYMBOL <= bps;
    ENABLE <= 1'b1;
    ew = w;
    last_a = last;
    exp_addr = 0;
    n_words = 0;
    chk = 1'b1;
    for (int i = 0; i < words * BD * 2 && n_words < words; i++) @(posedge CLK);
    if (n_words < words)
    begin
      n_errors++;
      report_and_stop();
    end
    ENABLE <= 1'b0;
    chk = 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  // Try one rate; check refusal and mode.
  task automatic rate_try(input logic [19:0] rate, input logic [3:0] bps,
                          input logic [1:0] filt, input logic cont, dir, err, par);
    @(posedge CLK);
    BIT_RATE_KBPS <= rate;
    BITS_PER_SYMBOL <= bps;
    FILTER_SELECT <= filt;
    CONTINUOUS_STREAM <= cont;
    DIRECT_PATTERN <= dir;
    ENABLE <= 1'b1;
    repeat (4) @(posedge CLK);
    `CHK(RATE_ERROR, err)
    `CHK(PLAYING, !err)
    if (!err) `CHK(PARALLEL_MODE, par)
    ENABLE <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  // Main sequence: reset, full buffer, four playbacks, rate limits.
  initial
  begin
    repeat (6) @(posedge CLK);
    `CHK(WORD, `TDPP_WORD_FIXED)
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (12) @(posedge CLK);
    `CHK(USER_READY, 1'b0)
    `CHK(n_taken, 8)
    run(8'h02, 8'h02, 2'h0, 3'h0, 20'h003e8, 4'h1, 1, 2499, 2510);
    `CHK(BLOCKS_NEEDED, 16'h000a)
    run(8'ha5, 8'h00, 2'h1, 3'h5, 20'h003e8, 4'h1, 1, 1249, 1260);
    `CHK(BLOCKS_NEEDED, 16'h0005)
    run(8'h5a, 8'h00, 2'h2, 3'h0, 20'h186a0, 4'h4, 4, 1249, 1260);
    run(8'hff, 8'h00, 2'h3, 3'h0, 20'h003e8, 4'h1, 1, 1249, 300);
    rate_try(20'h0c350, 4'h1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    rate_try(20'h0c351, 4'h1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    rate_try(20'h061a9, 4'h1, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    rate_try(20'h030d4, 4'h1, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    rate_try(20'h030d5, 4'h1, 2'h3, 1'b1, 1'b0, 1'b1, 1'b0);
    rate_try(20'h61a80, 4'h8, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    rate_try(20'h61a81, 4'h8, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    rate_try(20'h0c350, 4'h4, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    rate_try(20'h186a0, 4'h4, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    rate_try(20'h186a0, 4'h4, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule

// ### testbench/tdpp_user_source.sv
// Purpose: Stands in for the user data source feeding file bits.
// Assumes: Restart pulses only after the whole file was taken.
// Notes:   The data line toggles every cycle while nothing is offered.
`timescale 1ns/10ps
module tdpp_user_source (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  // Control from the bench and the block.
  input wire logic [15:0] file_bits,
  input wire logic        ready,
  input wire logic        restart,
  // Data toward the block.
  output logic            valid,
  output logic            bit_out
);
  logic [15:0] idx; // Next file bit to offer.
  logic        tog; // Filler that keeps an idle line from looking settled.
  // Offer held steady until taken, since idx only moves on acceptance or on a restart word.
  assign valid   = idx < file_bits;
  assign bit_out = valid ? idx[0] ^ idx[2] ^ idx[5] : tog;
  // The file is sent again from its first bit after each restart word.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      idx <= '0;
    else if (restart)
      idx <= '0;
    else if (valid && ready)
      idx <= idx + 1'b1;
  end
  // Toggle the filler each cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tog <= 1'b0;
    else
      tog <= ~tog;
  end
endmodule
